// [ssm_pkg.sv]
// constants, register map and types for the safety monitor block
package ssm_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int WD_TICK_NS = 20480;
   localparam int WD_TICK_CYCLES = (WD_TICK_NS + CLK_PERIOD_NS - 1) /
      CLK_PERIOD_NS;
   localparam logic [9:0] TICK_LAST = 10'(WD_TICK_CYCLES - 1);

   localparam logic [7:0] ADDR_WDCTRL = 8'h00;
   localparam logic [7:0] ADDR_WDPERIOD = 8'h04;
   localparam logic [7:0] ADDR_WDWINLOW = 8'h08;
   localparam logic [7:0] ADDR_SERVICE = 8'h0c;
   localparam logic [7:0] ADDR_WDCOUNT = 8'h10;
   localparam logic [7:0] ADDR_NMIPERIOD = 8'h14;
   localparam logic [7:0] ADDR_NMIFLAGS = 8'h18;
   localparam logic [7:0] ADDR_NMISHADOW = 8'h1c;
   localparam logic [7:0] ADDR_MCDCTRL = 8'h20;
   localparam logic [7:0] ADDR_CLKOUTCTRL = 8'h24;
   localparam logic [7:0] ADDR_LOCK = 8'h28;
   localparam logic [7:0] ADDR_PROTECT = 8'h2c;
   localparam logic [7:0] ADDR_INTSTAT = 8'h30;
   localparam logic [7:0] ADDR_INTMASK = 8'h34;

   localparam logic [7:0] SERVICE_KEY = 8'ha5;
   localparam logic [7:0] CTRL_KEY = 8'h5a;
   localparam int KEY_LSB = 24;

   localparam int WDC_MODE = 0;
   localparam int WDC_RESP = 1;
   localparam int WDC_EN = 2;
   localparam logic [2:0] WDCTRL_RST = 3'h4;
   localparam logic [15:0] WDPERIOD_RST = 16'h00ff;
   localparam logic [15:0] WDWINLOW_RST = 16'h0000;
   localparam logic [15:0] NMIPERIOD_RST = 16'h0100;
   localparam logic [7:0] MCD_LIMIT = 8'h10;

   localparam int LOCK_WD = 0;
   localparam int LOCK_MCD = 1;
   localparam int LOCK_CLKOUT = 2;
   localparam int NMI_CLKMISS = 0;

   localparam int IRQ_WDFAIL = 0;
   localparam int IRQ_NMI = 1;
   localparam int IRQ_CLKMISS = 2;
   localparam int IRQ_NMITIMEOUT = 3;

   typedef enum logic {SSM_MODE_NORMAL, SSM_MODE_WINDOW} ssm_mode_t;
endpackage : ssm_pkg

// [ssm_wdog_if.sv]
// signals between the register file and the watchdog core
`timescale 1ns/100ps
interface ssm_wdog_if;
   import ssm_pkg::*;
   logic tick;
   logic enable;
   ssm_mode_t mode;
   logic [15:0] period;
   logic [15:0] winLow;
   logic service;
   logic keyOk;
   logic [15:0] count;
   logic fail;
   modport ctrl (output tick, enable, mode, period, winLow, service, keyOk,
      input count, fail);
   modport core (input tick, enable, mode, period, winLow, service, keyOk,
      output count, fail);
endinterface : ssm_wdog_if

// [ssm_wdog_core.sv]
// watchdog counter with normal and windowed service checking
`timescale 1ns/100ps
module ssm_wdog_core
   import ssm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   ssm_wdog_if.core w
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         w.count <= 16'h0000;
         w.fail <= 1'b0;
      end else begin
         w.fail <= 1'b0;
         if (!w.enable) begin
            w.count <= 16'h0000;
         end else if (w.service) begin
            // any service restarts the count, good or bad
            w.count <= 16'h0000;
            if (!w.keyOk) begin
               w.fail <= 1'b1;
            end else if (w.mode == SSM_MODE_WINDOW && w.count < w.winLow)
            begin
               w.fail <= 1'b1;
            end
         end else if (w.tick) begin
            if (w.count >= w.period) begin
               w.count <= 16'h0000;
               w.fail <= 1'b1;
            end else begin
               w.count <= 16'(w.count + 16'h0001);
            end
         end
      end
   end

   a_bad_key_fails: assert property (@(posedge clk) disable iff (!rst_n)
      w.enable && w.service && !w.keyOk |=> w.fail)
      else $error("wrong service key did not raise a failure");
   a_early_window: assert property (@(posedge clk) disable iff (!rst_n)
      w.enable && w.service && w.keyOk && w.mode == SSM_MODE_WINDOW &&
      w.count < w.winLow |=> w.fail && w.count == 16'h0000)
      else $error("service before window opened was accepted");
endmodule : ssm_wdog_core

// [ssm_clk_detect.sv]
// loss-of-reference detector timed by the internal oscillator ticks
`timescale 1ns/100ps
module ssm_clk_detect
   import ssm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic oscTick,
   input wire logic refClkIn,
   input wire logic enable,
   output logic missPulse,
   output logic missing
);
   logic refPrev_reg;
   logic [7:0] gap_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         refPrev_reg <= 1'b0;
      end else begin
         refPrev_reg <= refClkIn;
      end
   end

   // only total silence is caught: any edge inside the limit restarts it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_reg <= 8'h00;
         missing <= 1'b0;
         missPulse <= 1'b0;
      end else begin
         missPulse <= 1'b0;
         if (!enable) begin
            gap_reg <= 8'h00;
            missing <= 1'b0;
         end else if (refClkIn != refPrev_reg) begin
            gap_reg <= 8'h00;
         end else if (oscTick && !missing) begin
            if (gap_reg >= 8'(MCD_LIMIT - 8'h01)) begin
               missing <= 1'b1;
               missPulse <= 1'b1;
            end else begin
               gap_reg <= 8'(gap_reg + 8'h01);
            end
         end
      end
   end

   a_miss_needs_en: assert property (@(posedge clk) disable iff (!rst_n)
      missPulse |-> $past(enable) && missing)
      else $error("missing clock flagged while detector was off");
endmodule : ssm_clk_detect

// [ssm_top.sv]
// system safety monitors: watchdog, nmi recovery, clock checks, locks
//
// Summary of operation
// - watchdog runs either normal timeout or windowed mode, selected by config.
// - normal mode: correct key before timeout; expiry or wrong key fails.
// - windowed mode: key only between lower and upper bound, else failure.
// - a failure gives warm reset or masked interrupt per response select.
// - after any reset the watchdog is enabled in normal mode.
// - a set lock bit blocks writes to its register until reset.
// - oscillator ticks detect total loss of the reference clock.
// - missing clock detector on from power-on, software may turn it off.
// - raised nmi starts recovery counter; reset if not recovered in period.
// - shadow copies of nmi flags survive warm reset, cleared by power-on.
// - watchdog control, period and window writes need the multi-bit key, always checked.
// - clock export output stays off after reset until software enables it.
// - write protection opened and closed by software; reads always allowed.
`timescale 1ns/100ps
module ssm_top
   import ssm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic porRst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   output logic [31:0] rdData,
   input wire logic oscTick,
   input wire logic refClkIn,
   input wire logic [2:0] nmiIn,
   output logic irq,
   output logic nmiOut,
   output logic warmRstReq,
   output logic clockExportOut
);
   logic [9:0] div_reg;
   logic tick;
   logic [2:0] wdCtrl_reg;
   logic [15:0] wdPeriod_reg;
   logic [15:0] wdWinLow_reg;
   logic [15:0] nmiPeriod_reg;
   logic [15:0] nmiCount_reg;
   logic [3:0] nmiFlags_reg;
   logic [3:0] nmiFlags_next;
   logic [3:0] nmiSet;
   logic [3:0] nmiClr;
   logic [3:0] nmiShadow_reg;
   logic nmiTimeout_reg;
   logic mcdOff_reg;
   logic clkOutEn_reg;
   logic [2:0] lock_reg;
   logic protectOpen_reg;
   logic [3:0] intStat_reg;
   logic [3:0] intMask_reg;
   logic [3:0] intEvent;
   logic mcdMissPulse;
   logic mcdMissing;
   logic wdCtrlWr;
   logic warmReq_next;

   ssm_wdog_if wdBus ();

   function automatic logic keyedWrite(input logic [7:0] a,
      input logic [31:0] d, input logic [7:0] target);
      keyedWrite = wrEn && a == target &&
         d[KEY_LSB +: 8] == CTRL_KEY;
   endfunction : keyedWrite

   function automatic logic protWrite(input logic [7:0] a,
      input logic [7:0] target);
      protWrite = wrEn && protectOpen_reg && a == target;
   endfunction : protWrite

   // watchdog timebase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= 10'h000;
         tick <= 1'b0;
      end else begin
         tick <= (div_reg == TICK_LAST);
         if (div_reg == TICK_LAST) begin
            div_reg <= 10'h000;
         end else begin
            div_reg <= 10'(div_reg + 10'h001);
         end
      end
   end

   // write protection window
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         protectOpen_reg <= 1'b0;
      end else if (wrEn && addr == ADDR_PROTECT) begin
         protectOpen_reg <= wrData[0];
      end
   end

   // lock bits only set by software, cleared by reset alone
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_reg <= 3'h0;
      end else if (protWrite(addr, ADDR_LOCK)) begin
         lock_reg <= lock_reg | wrData[2:0];
      end
   end

   assign wdCtrlWr = keyedWrite(addr, wrData, ADDR_WDCTRL) &&
      !lock_reg[LOCK_WD];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdCtrl_reg <= WDCTRL_RST;
         wdPeriod_reg <= WDPERIOD_RST;
         wdWinLow_reg <= WDWINLOW_RST;
      end else if (!lock_reg[LOCK_WD]) begin
         if (wdCtrlWr) begin
            wdCtrl_reg <= wrData[2:0];
         end
         if (keyedWrite(addr, wrData, ADDR_WDPERIOD)) begin
            wdPeriod_reg <= wrData[15:0];
         end
         if (keyedWrite(addr, wrData, ADDR_WDWINLOW)) begin
            wdWinLow_reg <= wrData[15:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mcdOff_reg <= 1'b0;
         clkOutEn_reg <= 1'b0;
         nmiPeriod_reg <= NMIPERIOD_RST;
      end else begin
         if (protWrite(addr, ADDR_MCDCTRL) && !lock_reg[LOCK_MCD]) begin
            mcdOff_reg <= wrData[0];
         end
         if (protWrite(addr, ADDR_CLKOUTCTRL) && !lock_reg[LOCK_CLKOUT])
         begin
            clkOutEn_reg <= wrData[0];
         end
         if (protWrite(addr, ADDR_NMIPERIOD)) begin
            nmiPeriod_reg <= wrData[15:0];
         end
      end
   end

   assign wdBus.tick = tick;
   assign wdBus.enable = wdCtrl_reg[WDC_EN];
   assign wdBus.mode = wdCtrl_reg[WDC_MODE] ? SSM_MODE_WINDOW :
      SSM_MODE_NORMAL;
   assign wdBus.period = wdPeriod_reg;
   assign wdBus.winLow = wdWinLow_reg;
   assign wdBus.service = wrEn && addr == ADDR_SERVICE;
   assign wdBus.keyOk = wrData[7:0] == SERVICE_KEY;

   ssm_wdog_core wdCore (
      .clk(clk),
      .rst_n(rst_n),
      .w(wdBus.core)
   );

   ssm_clk_detect clkDetect (
      .clk(clk),
      .rst_n(rst_n),
      .oscTick(oscTick),
      .refClkIn(refClkIn),
      .enable(!mcdOff_reg),
      .missPulse(mcdMissPulse),
      .missing(mcdMissing)
   );

   // nmi flags: a new event wins over a clear in the same cycle
   assign nmiSet = {nmiIn, mcdMissPulse};
   assign nmiClr = (wrEn && addr == ADDR_NMIFLAGS) ? wrData[3:0] : 4'h0;
   assign nmiFlags_next = (nmiFlags_reg & ~nmiClr) | nmiSet;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nmiFlags_reg <= 4'h0;
         nmiOut <= 1'b0;
      end else begin
         nmiFlags_reg <= nmiFlags_next;
         nmiOut <= |nmiFlags_next;
      end
   end

   // recovery counter restarts on any clear so a partial fix buys time
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nmiCount_reg <= 16'h0000;
         nmiTimeout_reg <= 1'b0;
      end else begin
         nmiTimeout_reg <= 1'b0;
         if (nmiFlags_reg == 4'h0 || nmiClr != 4'h0) begin
            nmiCount_reg <= 16'h0000;
         end else if (tick) begin
            if (nmiCount_reg >= nmiPeriod_reg) begin
               nmiCount_reg <= 16'h0000;
               nmiTimeout_reg <= 1'b1;
            end else begin
               nmiCount_reg <= 16'(nmiCount_reg + 16'h0001);
            end
         end
      end
   end

   assign warmReq_next = nmiTimeout_reg ||
      (wdBus.fail && !wdCtrl_reg[WDC_RESP]);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         warmRstReq <= 1'b0;
      end else begin
         warmRstReq <= warmReq_next;
      end
   end

   // shadow lives on the power-on reset only, so it outlasts a warm reset
   always_ff @(posedge clk or negedge porRst_n) begin
      if (!porRst_n) begin
         nmiShadow_reg <= 4'h0;
      end else if (rst_n && warmReq_next) begin
         nmiShadow_reg <= nmiFlags_next;
      end
   end

   // exports clk/2 so the pad never sees a full-rate clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clockExportOut <= 1'b0;
      end else if (!clkOutEn_reg) begin
         clockExportOut <= 1'b0;
      end else begin
         clockExportOut <= !clockExportOut;
      end
   end

   assign intEvent[IRQ_WDFAIL] = wdBus.fail && wdCtrl_reg[WDC_RESP];
   assign intEvent[IRQ_NMI] = |nmiSet;
   assign intEvent[IRQ_CLKMISS] = mcdMissPulse;
   assign intEvent[IRQ_NMITIMEOUT] = nmiTimeout_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         intStat_reg <= 4'h0;
         intMask_reg <= 4'h0;
      end else begin
         if (wrEn && addr == ADDR_INTSTAT) begin
            intStat_reg <= (intStat_reg & ~wrData[3:0]) | intEvent;
         end else begin
            intStat_reg <= intStat_reg | intEvent;
         end
         if (wrEn && addr == ADDR_INTMASK) begin
            intMask_reg <= wrData[3:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(intStat_reg & intMask_reg);
      end
   end

   // read data stands for exactly the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData <= 32'h0000_0000;
      end else begin
         rdData <= 32'h0000_0000;
         if (rdEn) begin
            case (addr)
               ADDR_WDCTRL: rdData <= {29'h0, wdCtrl_reg};
               ADDR_WDPERIOD: rdData <= {16'h0, wdPeriod_reg};
               ADDR_WDWINLOW: rdData <= {16'h0, wdWinLow_reg};
               ADDR_WDCOUNT: rdData <= {16'h0, wdBus.count};
               ADDR_NMIPERIOD: rdData <= {16'h0, nmiPeriod_reg};
               ADDR_NMIFLAGS: rdData <= {28'h0, nmiFlags_reg};
               ADDR_NMISHADOW: rdData <= {28'h0, nmiShadow_reg};
               ADDR_MCDCTRL: rdData <= {30'h0, mcdMissing, mcdOff_reg};
               ADDR_CLKOUTCTRL: rdData <= {31'h0, clkOutEn_reg};
               ADDR_LOCK: rdData <= {29'h0, lock_reg};
               ADDR_PROTECT: rdData <= {31'h0, protectOpen_reg};
               ADDR_INTSTAT: rdData <= {28'h0, intStat_reg};
               ADDR_INTMASK: rdData <= {28'h0, intMask_reg};
               default: rdData <= 32'h0000_0000;
            endcase
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_mode_keyed: assert property (
      $changed(wdCtrl_reg) |-> $past(wrEn) && $past(addr) == ADDR_WDCTRL &&
      $past(wrData[31:24]) == CTRL_KEY)
      else $error("watchdog control changed without the key");
   a_lock_blocks: assert property (
      lock_reg[LOCK_WD] && wrEn && addr == ADDR_WDCTRL
      |=> $stable(wdCtrl_reg))
      else $error("locked watchdog control was written");
   a_lock_sticky: assert property (
      lock_reg[LOCK_WD] |=> lock_reg[LOCK_WD])
      else $error("lock bit cleared without reset");
   a_fail_reset: assert property (
      wdBus.fail && !wdCtrl_reg[WDC_RESP] |=> warmRstReq)
      else $error("watchdog failure gave no warm reset");
   a_fail_irq: assert property (
      wdBus.fail && wdCtrl_reg[WDC_RESP] && intMask_reg[IRQ_WDFAIL] &&
      !(wrEn && addr == ADDR_INTMASK) |=> ##1 irq)
      else $error("watchdog failure gave no interrupt");
   a_nmi_timeout: assert property (
      tick && nmiFlags_reg != 4'h0 && nmiClr == 4'h0 &&
      nmiCount_reg >= nmiPeriod_reg |=> ##1 warmRstReq)
      else $error("nmi recovery expiry gave no reset");
   a_nmi_restart: assert property (
      nmiClr != 4'h0 |=> nmiCount_reg == 16'h0000)
      else $error("nmi counter not restarted on clear");
   a_shadow_keep: assert property (
      warmRstReq |-> nmiShadow_reg == $past(nmiFlags_next))
      else $error("shadow did not capture nmi flags");
   a_clkout_off: assert property (
      !clkOutEn_reg |=> !clockExportOut)
      else $error("clock exported while disabled");
   a_protect_mcd: assert property (
      !protectOpen_reg && wrEn && addr == ADDR_MCDCTRL
      |=> $stable(mcdOff_reg))
      else $error("protected detector control was written");

   c_wd_expiry: cover property (tick && wdBus.count >= wdPeriod_reg ##1
      wdBus.fail);
   c_window_service: cover property (wdBus.service && wdBus.keyOk &&
      wdBus.mode == SSM_MODE_WINDOW && wdBus.count >= wdWinLow_reg);
   c_clock_missing: cover property (mcdMissPulse ##[1:4] nmiOut);
   c_nmi_reset: cover property (nmiTimeout_reg ##1 warmRstReq);
endmodule : ssm_top

// [ssm_top_test.sv]
// self-checking register-level bench for the safety monitor block
`timescale 1ns/100ps
module ssm_top_test;
   import ssm_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic porRst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wrData = 32'h0;
   logic wrEn = 1'b0;
   logic rdEn = 1'b0;
   logic [31:0] rdData;
   logic oscTick = 1'b0;
   logic refClkIn = 1'b0;
   logic [2:0] nmiIn = 3'h0;
   logic irq;
   logic nmiOut;
   logic warmRstReq;
   logic clockExportOut;
   logic refRun = 1'b1;
   logic [1:0] oscDiv = 2'h0;
   logic [31:0] v;
   logic [7:0] k;
   int fails = 0;
   int cmp_count = 0;
   int rstCount = 0;
   int base;

   always #20 clk = ~clk;

   ssm_top u_dut (
      .clk(clk),
      .rst_n(rst_n),
      .porRst_n(porRst_n),
      .addr(addr),
      .wrData(wrData),
      .wrEn(wrEn),
      .rdEn(rdEn),
      .rdData(rdData),
      .oscTick(oscTick),
      .refClkIn(refClkIn),
      .nmiIn(nmiIn),
      .irq(irq),
      .nmiOut(nmiOut),
      .warmRstReq(warmRstReq),
      .clockExportOut(clockExportOut)
   );

   // oscillator pulse every third clock; the reference toggles unless stopped
   always @(posedge clk) begin
      oscDiv <= (oscDiv == 2'h2) ? 2'h0 : oscDiv + 2'h1;
      oscTick <= (oscDiv == 2'h2);
      if (refRun) begin
         refClkIn <= ~refClkIn;
      end
   end

   // reset requests are single pulses, so count them as they pass
   always @(posedge clk) begin
      if (warmRstReq === 1'b1) begin
         rstCount <= rstCount + 1;
      end
   end

   task give_verdict;
      if (fails == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : give_verdict

   task chk(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task pause(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : pause

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      #1;
      d = rdData;
   endtask : rd

   task do_reset(input logic cold);
      @(posedge clk);
      rst_n <= 1'b0;
      porRst_n <= ~cold;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      porRst_n <= 1'b1;
   endtask : do_reset

   initial begin
      #(40 * 20000);
      fails++;
      give_verdict();
   end

   initial begin
      k = CTRL_KEY;
      do_reset(1'b1);
      rd(ADDR_WDCTRL, v);
      chk("wdctrl reset", v, 32'(WDCTRL_RST));
      rd(ADDR_WDPERIOD, v);
      chk("wdperiod reset", v, 32'(WDPERIOD_RST));
      rd(ADDR_WDCOUNT, v);
      chk("count reset", v, 32'h0);
      rd(ADDR_MCDCTRL, v);
      chk("mcd reset", v, 32'h0);
      rd(ADDR_CLKOUTCTRL, v);
      chk("clkout reset", v, 32'h0);
      chk("clkout pin", {31'h0, clockExportOut}, 32'h0);
      rd(8'h3c, v);
      chk("unmapped", v, 32'h0);
      // keyless write must be dropped, keyed write lands
      wr(ADDR_WDPERIOD, 32'h00000002);
      rd(ADDR_WDPERIOD, v);
      chk("unkeyed period", v, 32'(WDPERIOD_RST));
      wr(ADDR_WDPERIOD, {k, 24'h000002});
      rd(ADDR_WDPERIOD, v);
      chk("keyed period", v, 32'h00000002);
      base = rstCount;
      repeat (8) begin
         wr(ADDR_SERVICE, 32'(SERVICE_KEY));
         pause(250);
      end
      chk("serviced quiet", 32'(rstCount - base), 32'h0);
      pause(1600);
      chk("timeout reset", 32'(rstCount > base), 32'h1);
      // interrupt response on a wrong key
      wr(ADDR_WDCTRL, {k, 24'h000006});
      wr(ADDR_INTMASK, 32'h00000001);
      wr(ADDR_SERVICE, 32'(SERVICE_KEY));
      base = rstCount;
      wr(ADDR_SERVICE, 32'h0000003c);
      pause(4);
      chk("wrong key irq", {31'h0, irq}, 32'h1);
      chk("no reset", 32'(rstCount - base), 32'h0);
      wr(ADDR_SERVICE, 32'(SERVICE_KEY));
      wr(ADDR_INTSTAT, 32'h00000001);
      pause(3);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      wr(ADDR_INTMASK, 32'h00000000);
      wr(ADDR_SERVICE, 32'h0000003c);
      pause(4);
      chk("masked irq", {31'h0, irq}, 32'h0);
      rd(ADDR_INTSTAT, v);
      chk("masked status", v & 32'h1, 32'h1);
      wr(ADDR_SERVICE, 32'(SERVICE_KEY));
      wr(ADDR_INTSTAT, 32'h00000001);
      wr(ADDR_INTMASK, 32'h00000001);
      // windowed mode: early key fails, key inside the window passes
      wr(ADDR_WDWINLOW, {k, 24'h000001});
      wr(ADDR_WDPERIOD, {k, 24'h000003});
      wr(ADDR_WDCTRL, {k, 24'h000007});
      rd(ADDR_WDCTRL, v);
      chk("window mode", v, 32'h00000007);
      wr(ADDR_SERVICE, 32'(SERVICE_KEY));
      wr(ADDR_SERVICE, 32'(SERVICE_KEY));
      pause(3);
      chk("early key", {31'h0, irq}, 32'h1);
      wr(ADDR_INTSTAT, 32'h00000001);
      pause(600);
      rd(ADDR_WDCOUNT, v);
      chk("count advances", 32'(v != 32'h0), 32'h1);
      wr(ADDR_SERVICE, 32'(SERVICE_KEY));
      pause(3);
      chk("key in window", {31'h0, irq}, 32'h0);
      // lock holds until a reset
      wr(ADDR_PROTECT, 32'h00000001);
      wr(ADDR_LOCK, 32'h00000001);
      wr(ADDR_WDCTRL, {k, 24'h000004});
      rd(ADDR_WDCTRL, v);
      chk("locked wdctrl", v, 32'h00000007);
      do_reset(1'b0);
      rd(ADDR_WDCTRL, v);
      chk("wdctrl after reset", v, 32'(WDCTRL_RST));
      rd(ADDR_LOCK, v);
      chk("lock after reset", v, 32'h0);
      // protection closed after reset
      wr(ADDR_CLKOUTCTRL, 32'h00000001);
      rd(ADDR_CLKOUTCTRL, v);
      chk("protected clkout", v, 32'h0);
      wr(ADDR_PROTECT, 32'h00000001);
      wr(ADDR_CLKOUTCTRL, 32'h00000001);
      rd(ADDR_CLKOUTCTRL, v);
      chk("open clkout", v, 32'h00000001);
      pause(1);
      v = {31'h0, clockExportOut};
      pause(1);
      chk("clkout toggles", {31'h0, clockExportOut} ^ v, 32'h1);
      wr(ADDR_MCDCTRL, 32'h00000001);
      rd(ADDR_MCDCTRL, v);
      chk("mcd off", v, 32'h00000001);
      wr(ADDR_MCDCTRL, 32'h00000000);
      // reference loss raises a flag; recovery counter then asks reset
      wr(ADDR_WDCTRL, {k, 24'h000000});
      wr(ADDR_NMIPERIOD, 32'h00000001);
      base = rstCount;
      refRun = 1'b0;
      pause(80);
      rd(ADDR_MCDCTRL, v);
      chk("clock missing", v, 32'h00000002);
      rd(ADDR_NMIFLAGS, v);
      chk("missing flag", v & 32'h1, 32'h1);
      chk("nmi out", {31'h0, nmiOut}, 32'h1);
      pause(1500);
      chk("recovery reset", 32'(rstCount > base), 32'h1);
      rd(ADDR_NMISHADOW, v);
      chk("shadow load", v, 32'h00000001);
      refRun = 1'b1;
      do_reset(1'b0);
      rd(ADDR_NMISHADOW, v);
      chk("shadow warm", v, 32'h00000001);
      do_reset(1'b1);
      rd(ADDR_NMISHADOW, v);
      chk("shadow cold", v, 32'h0);
      // external events and their clear
      @(posedge clk);
      nmiIn <= 3'h5;
      @(posedge clk);
      nmiIn <= 3'h0;
      pause(2);
      rd(ADDR_NMIFLAGS, v);
      chk("nmi flags", v, 32'h0000000a);
      wr(ADDR_NMIFLAGS, 32'h0000000f);
      pause(2);
      chk("nmi cleared", {31'h0, nmiOut}, 32'h0);
      give_verdict();
   end
endmodule : ssm_top_test
